// File: design/ctrl_pins_map.svh
`ifndef CTRL_PINS_MAP_SVH
`define CTRL_PINS_MAP_SVH
`define BYTE_BITS        4'h8
`define DIR_RESET        1'h1
`define LEVEL_RESET      1'h0
`define SYNC_EN_RESET    1'h0
`define MCLK_OFF_RESET   1'h0
`define SYNC_PULSE_NS    50
`define SYNC_PULSE_CYC   ((`SYNC_PULSE_NS * 25 + 999) / 1000)
`endif

// File: design/ctrl_pins_pkg.sv
`default_nettype none
package ctrl_pins_pkg;
  typedef enum logic [1:0] {
    LINK_IDLE  = 2'b00,
    LINK_SHIFT = 2'b01,
    LINK_BYTE  = 2'b10
  } link_state_t;
endpackage
`default_nettype wire

// File: design/sync2.sv
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // Asynchronous level in, synchronised level out.
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic stage1_r;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stage1_r <= RESET_VAL;
      syncOut  <= RESET_VAL;
    end else begin
      stage1_r <= asyncIn;
      syncOut  <= stage1_r;
    end
  end
endmodule // sync2
`default_nettype wire

// File: design/control_pins_and_io_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "ctrl_pins_map.svh"
module control_pins_and_io_port
  import ctrl_pins_pkg::*;
#(
  parameter int BYTE_LEN = 8
) (
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // Serial link pins.
  input  wire logic serialClk,
  input  wire logic chipSelect_n,
  input  wire logic serialDataIn,
  // Received bytes.
  output logic [7:0] rxByte,
  output logic       rxByteValid,
  // Master clock.
  input  wire logic master_clock_in,
  input  wire logic master_clock_out_disable,
  output logic      master_clock_out,
  // Port bits.
  input  wire logic common_pin_direction,
  input  wire logic common_pin_level,
  input  wire logic sync_pin_direction,
  input  wire logic sync_pin_level,
  input  wire logic syncEnable,
  output logic      commonIsAnalog,
  output logic      sync_pin_level_rd,
  output logic      filterSyncPulse,
  // Port pins.
  output logic      analog_common_or_out_pin_o,
  output logic      analog_common_or_out_pin_oe,
  input  wire logic filter_sync_or_io_pin_i,
  output logic      filter_sync_or_io_pin_o,
  output logic      filter_sync_or_io_pin_oe
);

  // The three-bit counter serves eight-bit frames only.
  if (BYTE_LEN != 8) begin : gBadLen
    $error("BYTE_LEN must be 8");
  end

  logic        sclkS;
  logic        csS;
  logic        dinS;
  logic        syncPinS;
  logic        sclkPrev_r;
  logic        csPrev_r;
  logic [2:0]  bitCnt_r;
  logic [7:0]  shift_r;
  logic        syncPrev_r;
  link_state_t state_r;
  logic        sclkRise;
  logic        csFall;
  logic        csRise;

  sync2 uSclk (.ref_clk(ref_clk), .reset_n(reset_n), .asyncIn(serialClk), .syncOut(sclkS));
  // Select path resets high, matching the pulled-up pin, so release brings no false edge.
  sync2 #(.RESET_VAL(1'b1)) uCs (.ref_clk(ref_clk), .reset_n(reset_n), .asyncIn(chipSelect_n),
                                 .syncOut(csS));
  sync2 uDin  (.ref_clk(ref_clk), .reset_n(reset_n), .asyncIn(serialDataIn), .syncOut(dinS));
  sync2 uSync (.ref_clk(ref_clk), .reset_n(reset_n), .asyncIn(filter_sync_or_io_pin_i),
               .syncOut(syncPinS));

  assign sclkRise = sclkS && !sclkPrev_r;
  assign csFall   = !csS && csPrev_r;
  assign csRise   = csS && !csPrev_r;

  // Edge history; chip select resets high so a floating, pulled-up pin stays deselected.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sclkPrev_r <= 1'b0;
      csPrev_r   <= 1'b1;
    end else begin
      sclkPrev_r <= sclkS;
      csPrev_r   <= csS;
    end
  end

  // Byte assembly; a chip select edge restarts the byte count, so a tied-low select runs free.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_r     <= LINK_IDLE;
      bitCnt_r    <= 3'h0;
      shift_r     <= 8'h00;
      rxByte      <= 8'h00;
      rxByteValid <= 1'b0;
    end else begin
      rxByteValid <= 1'b0;
      if (csS || csFall) begin
        state_r  <= csS ? LINK_IDLE : LINK_SHIFT;
        bitCnt_r <= 3'h0;
      end else if (sclkRise) begin
        shift_r  <= {shift_r[6:0], dinS};
        bitCnt_r <= bitCnt_r + 3'h1;
        state_r  <= LINK_SHIFT;
        if (bitCnt_r == 3'h7) begin
          rxByte      <= {shift_r[6:0], dinS};
          rxByteValid <= 1'b1;
          state_r     <= LINK_BYTE;
        end
      end
    end
  end

  // Inverted clock out, held low when disabled.
  assign master_clock_out = !master_clock_out_disable && !master_clock_in;

  // Common pin: digital output unless its direction bit is one.
  assign commonIsAnalog              = common_pin_direction;
  assign analog_common_or_out_pin_oe = !common_pin_direction;
  assign analog_common_or_out_pin_o  = common_pin_direction ? 1'b0 : common_pin_level;

  // Sync pin: output when direction bit clear and sync mode off.
  assign filter_sync_or_io_pin_oe = !sync_pin_direction && !syncEnable;
  assign filter_sync_or_io_pin_o  = filter_sync_or_io_pin_oe ? sync_pin_level : 1'b0;

  // Read value and filter sync pulse on the falling edge of the synchronised pin.
  // The edge history resets to the synchroniser's own reset level, so a low pin
  // does not look like a falling edge just after reset.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      syncPrev_r        <= 1'b0;
      sync_pin_level_rd <= `LEVEL_RESET;
      filterSyncPulse   <= 1'b0;
    end else begin
      syncPrev_r        <= syncPinS;
      sync_pin_level_rd <= filter_sync_or_io_pin_oe ? sync_pin_level : syncPinS;
      filterSyncPulse   <= syncEnable && syncPrev_r && !syncPinS;
    end
  end

  // Steps that take a bit, end a byte and start a filter sync pulse.
  sequence bitTaken;
    !csS && !csFall && sclkRise;
  endsequence

  sequence lastBitSeen;
    !csS && !csFall && sclkRise && bitCnt_r == 3'h7;
  endsequence

  sequence syncFallSeen;
    syncEnable && syncPrev_r && !syncPinS;
  endsequence

  // Link byte assembly.
  byte_strobe_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rxByteValid |-> $past(sclkRise) && !$past(csS))
    else $error("Byte strobe without serial clock edge.");

  byte_done_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    lastBitSeen |=> rxByteValid)
    else $error("Eighth bit did not complete a byte.");

  byte_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rxByteValid |=> !rxByteValid)
    else $error("Byte strobe longer than one cycle.");

  byte_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !rxByteValid |-> $stable(rxByte))
    else $error("Received byte changed without a strobe.");

  bit_count_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    bitTaken |=> bitCnt_r == $past(bitCnt_r) + 3'h1)
    else $error("Serial clock edge not counted.");

  cs_restart_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    csFall |=> bitCnt_r == 3'h0)
    else $error("Chip select fall did not restart the byte.");

  cs_idle_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    csS [*2] |-> !rxByteValid)
    else $error("Byte accepted while deselected.");

  cs_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    csS |=> bitCnt_r == 3'h0)
    else $error("Bit count kept while deselected.");

  // Master clock output.
  mclk_inv_a: assert property (@(posedge ref_clk)
    !master_clock_out_disable |-> master_clock_out != master_clock_in)
    else $error("Master clock output not inverted.");

  mclk_off_a: assert property (@(posedge ref_clk)
    master_clock_out_disable |-> !master_clock_out)
    else $error("Master clock output toggles while disabled.");

  // Port pins.
  com_out_a: assert property (@(posedge ref_clk)
    !common_pin_direction |-> analog_common_or_out_pin_oe
      && analog_common_or_out_pin_o == common_pin_level)
    else $error("Common pin does not drive its value.");

  com_in_a: assert property (@(posedge ref_clk)
    common_pin_direction |-> !analog_common_or_out_pin_oe && commonIsAnalog)
    else $error("Common pin drives while an analog input.");

  sync_out_a: assert property (@(posedge ref_clk)
    !sync_pin_direction && !syncEnable |-> filter_sync_or_io_pin_oe
      && filter_sync_or_io_pin_o == sync_pin_level)
    else $error("Sync pin does not drive its value.");

  sync_input_a: assert property (@(posedge ref_clk)
    syncEnable |-> !filter_sync_or_io_pin_oe)
    else $error("Sync pin drives while in sync mode.");

  // Filter sync and read back.
  sync_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    filterSyncPulse |-> $past(syncEnable) && $past(syncPinS, 2) && !$past(syncPinS))
    else $error("Filter sync without pin falling edge.");

  sync_fire_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    syncFallSeen |=> filterSyncPulse)
    else $error("Pin falling edge gave no filter sync.");

  sync_once_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    filterSyncPulse |=> !filterSyncPulse)
    else $error("Filter sync longer than one cycle.");

  sync_rd_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !filter_sync_or_io_pin_oe && $stable(filter_sync_or_io_pin_oe) |=>
      sync_pin_level_rd == $past(syncPinS))
    else $error("Sync pin read value wrong.");

  sync_echo_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    filter_sync_or_io_pin_oe |=> sync_pin_level_rd == $past(sync_pin_level))
    else $error("Sync pin read value differs from driven value.");

  // Reset.
  reset_clr_a: assert property (@(posedge ref_clk)
    !reset_n |=> !rxByteValid && bitCnt_r == 3'h0)
    else $error("Reset did not clear link logic.");

endmodule // control_pins_and_io_port
`default_nettype wire

// File: tb/host_link_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_link_model (
  // Clock.
  input  wire logic ref_clk,
  // Link pins.
  output logic      serialClk,
  output logic      chipSelect_n,
  output logic      serialDataIn
);
  initial begin
    serialClk = 1'h0;
    chipSelect_n = 1'h1;
    serialDataIn = 1'h0;
  end
  // Sends n bits MSB first with a 320 ns link clock that rests low between frames.
  task automatic send(input logic [7:0] d, input int n, input logic hold);
    for (int i = 7; i > 7 - n; i--) begin
      chipSelect_n <= 1'h0;
      serialDataIn <= d[i];
      repeat (4) @(posedge ref_clk);
      serialClk <= 1'h1;
      repeat (4) @(posedge ref_clk);
      serialClk <= 1'h0;
    end
    repeat (4) @(posedge ref_clk);
    chipSelect_n <= hold ? 1'h0 : 1'h1;
    serialDataIn <= ~serialDataIn;
    // Let the select level stand before any following frame may change it.
    repeat (4) @(posedge ref_clk);
  endtask
endmodule // host_link_model
`default_nettype wire

// File: tb/control_pins_and_io_port_tb.sv
`timescale 1ns/1ns
`default_nettype none
module control_pins_and_io_port_tb;
  logic       ref_clk, reset_n, master_clock_in, master_clock_out_disable, syncEnable;
  logic       common_pin_direction, common_pin_level, sync_pin_direction, sync_pin_level;
  logic       pinDrv, rxByteValid, master_clock_out, commonIsAnalog, sync_pin_level_rd;
  logic       filterSyncPulse, analog_common_or_out_pin_o, analog_common_or_out_pin_oe;
  logic       filter_sync_or_io_pin_o, filter_sync_or_io_pin_oe;
  logic [7:0] rxByte;
  wire logic  serialClk, chipSelect_n, serialDataIn, filter_sync_or_io_pin_i;
  int         badCount = 0;
  int         samplesChecked = 0;
  assign filter_sync_or_io_pin_i = filter_sync_or_io_pin_oe ? filter_sync_or_io_pin_o : pinDrv;
  control_pins_and_io_port #(.BYTE_LEN(8)) dut_u (
    .ref_clk                     (ref_clk),
    .reset_n                     (reset_n),
    .serialClk                   (serialClk),
    .chipSelect_n                (chipSelect_n),
    .serialDataIn                (serialDataIn),
    .rxByte                      (rxByte),
    .rxByteValid                 (rxByteValid),
    .master_clock_in             (master_clock_in),
    .master_clock_out_disable    (master_clock_out_disable),
    .master_clock_out            (master_clock_out),
    .common_pin_direction        (common_pin_direction),
    .common_pin_level            (common_pin_level),
    .sync_pin_direction          (sync_pin_direction),
    .sync_pin_level              (sync_pin_level),
    .syncEnable                  (syncEnable),
    .commonIsAnalog              (commonIsAnalog),
    .sync_pin_level_rd           (sync_pin_level_rd),
    .filterSyncPulse             (filterSyncPulse),
    .analog_common_or_out_pin_o  (analog_common_or_out_pin_o),
    .analog_common_or_out_pin_oe (analog_common_or_out_pin_oe),
    .filter_sync_or_io_pin_i     (filter_sync_or_io_pin_i),
    .filter_sync_or_io_pin_o     (filter_sync_or_io_pin_o),
    .filter_sync_or_io_pin_oe    (filter_sync_or_io_pin_oe)
  );
  host_link_model host_u (.ref_clk(ref_clk), .serialClk(serialClk),
    .chipSelect_n(chipSelect_n), .serialDataIn(serialDataIn));
  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    master_clock_in = 1'h0;
    forever begin
      @(posedge ref_clk);
      master_clock_in <= ~master_clock_in;
    end
  end
  task automatic testDone();
    if (badCount == 0 && samplesChecked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic waitHigh(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'h1) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > lim) begin
        badCount++;
        testDone();
      end
    end
  endtask
  task automatic xfer(input logic [7:0] d, input logic hold);
    fork
      host_u.send(d, 8, hold);
      begin
        waitHigh(rxByteValid, 200);
        check(rxByte, d);
      end
    join
  endtask
  task automatic doReset();
    repeat (20) begin
      @(posedge ref_clk);
      reset_n <= 1'h0;
      #1;
      check(rxByteValid, 0);
      check(master_clock_out, !master_clock_in);
    end
    @(posedge ref_clk);
    reset_n <= 1'h1;
    repeat (3) @(posedge ref_clk);
  endtask
  initial begin
    {reset_n, master_clock_out_disable, syncEnable, pinDrv} = 4'h0;
    {common_pin_direction, common_pin_level, sync_pin_direction, sync_pin_level} = 4'h0;
    doReset();
    xfer(8'hA5, 1'h0);
    host_u.send(8'hFF, 3, 1'h0);
    xfer(8'h3C, 1'h0);
    repeat (2) begin
      @(posedge ref_clk);
      #1;
      check(master_clock_out, !master_clock_in);
    end
    @(posedge ref_clk);
    master_clock_out_disable <= 1'h1;
    repeat (2) begin
      @(posedge ref_clk);
      #1;
      check(master_clock_out, 0);
    end
    @(posedge ref_clk);
    master_clock_out_disable <= 1'h0;
    repeat (2) begin
      @(posedge ref_clk);
      #1;
      check(master_clock_out, !master_clock_in);
    end
    common_pin_level <= 1'h1;
    sync_pin_level <= 1'h1;
    repeat (3) @(posedge ref_clk);
    #1;
    check(analog_common_or_out_pin_oe, 1);
    check(analog_common_or_out_pin_o, 1);
    check(commonIsAnalog, 0);
    check(filter_sync_or_io_pin_oe, 1);
    check(filter_sync_or_io_pin_o, 1);
    check(sync_pin_level_rd, 1);
    @(posedge ref_clk);
    common_pin_direction <= 1'h1;
    sync_pin_direction <= 1'h1;
    repeat (4) @(posedge ref_clk);
    #1;
    check(analog_common_or_out_pin_oe, 0);
    check(commonIsAnalog, 1);
    check(filter_sync_or_io_pin_oe, 0);
    check(sync_pin_level_rd, 0);
    @(posedge ref_clk);
    pinDrv <= 1'h1;
    syncEnable <= 1'h1;
    repeat (5) @(posedge ref_clk);
    pinDrv <= 1'h0;
    @(posedge ref_clk);
    #1;
    check(filterSyncPulse, 0);
    waitHigh(filterSyncPulse, 6);
    check(filterSyncPulse, 1);
    @(posedge ref_clk);
    #1;
    check(filterSyncPulse, 0);
    sync_pin_direction <= 1'h0;
    @(posedge ref_clk);
    #1;
    check(filter_sync_or_io_pin_oe, 0);
    host_u.send(8'h00, 0, 1'h1);
    doReset();
    xfer(8'h96, 1'h1);
    xfer(8'h69, 1'h1);
    testDone();
  end
endmodule // control_pins_and_io_port_tb
`default_nettype wire
